// *** hdl/ppis_top.sv ***
// module: interrupt enable, request and status read logic of the parallel port
`timescale 1ns/100ps
`default_nettype none
module ppis_top (
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        IF_RESET_I,
  input  wire logic        FULL_MODE_I,
  input  wire logic        HS_CTL_SET_I,
  input  wire logic        HS_FLAG_READY_I,
  input  wire logic        EXT_REQ_N_I,
  input  wire logic        PERIPH_OK_I,
  input  wire logic [1:0]  CAUSE_N_I,
  input  wire logic [15:0] DATA_IN_I,
  input  wire logic        MASK_WR_I,
  input  wire logic [7:0]  MASK_DATA_I,
  input  wire logic        INTR_TAKEN_I,
  input  wire logic [3:0]  STATUS_ADDR_I,
  input  wire logic        STATUS_RD_I,
  output logic      [15:0] STATUS_DATA_O,
  output logic             STATUS_VALID_O,
  output logic      [7:0]  MASK_O,
  output logic             IRQ_O
);
  ppis_line_if lines ();

  logic        ready_now;
  logic [15:0] mux_rdata;
  logic [7:0]  mask_r;
  logic [7:0]  mask_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;

  // all checks below run on the one clock and rest while the system reset is high
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SYS_RST_I);

  // ready condition depends on the handshake option switch
  always_comb begin
    if (FULL_MODE_I) begin
      ready_now = !HS_CTL_SET_I && HS_FLAG_READY_I;
    end else begin
      ready_now = !HS_CTL_SET_I;
    end
  end

  // line states as seen by software, active-low lines turned into "line low" bits
  assign lines.ready       = ready_now;
  assign lines.ext_req_low = !EXT_REQ_N_I;
  assign lines.periph_ok   = PERIPH_OK_I;
  assign lines.cause_low   = ~CAUSE_N_I;
  assign lines.data_in     = DATA_IN_I;

  ppis_status_mux u_mux (
    .lines   (lines),
    .addr_i  (STATUS_ADDR_I),
    .rdata_o (mux_rdata)
  );

  // enable mask: interface reset first, a fresh write beats a taken interrupt
  always_comb begin
    if (IF_RESET_I) begin
      mask_nxt = ppis_pkg::MASK_RESET;
    end else if (MASK_WR_I) begin
      mask_nxt = MASK_DATA_I;
    end else if (INTR_TAKEN_I) begin
      mask_nxt = ppis_pkg::MASK_RESET;
    end else begin
      mask_nxt = mask_r;
    end
  end

  // single request from present levels only, so a vanished level drops it again
  always_comb begin
    irq_nxt = (mask_r[ppis_pkg::MASK_READY_BIT] && ready_now)
           || (mask_r[ppis_pkg::MASK_EXT_BIT] && !EXT_REQ_N_I);
  end

  // status read: value captured at the strobe and held until the next read
  always_comb begin
    rvalid_nxt = STATUS_RD_I;
    if (STATUS_RD_I) begin
      rdata_nxt = mux_rdata;
    end else begin
      rdata_nxt = rdata_r;
    end
  end

  // enable mask register; system reset blocks every source until software writes again
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mask_r <= ppis_pkg::MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // request register; registered so the host never sees a combinational glitch
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // read data and its one-cycle marker
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata_r  <= ppis_pkg::RDATA_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign STATUS_DATA_O  = rdata_r;
  assign STATUS_VALID_O = rvalid_r;
  assign MASK_O         = mask_r;
  assign IRQ_O          = irq_r;

  // checks

  sequence s_read_ready;
    STATUS_RD_I && STATUS_ADDR_I == ppis_pkg::REG_READY;
  endsequence

  sequence s_read_periph;
    STATUS_RD_I && STATUS_ADDR_I == ppis_pkg::REG_PERIPH;
  endsequence

  sequence s_enable_ready;
    MASK_WR_I && !IF_RESET_I && MASK_DATA_I[ppis_pkg::MASK_READY_BIT]
      && !MASK_DATA_I[ppis_pkg::MASK_EXT_BIT];
  endsequence

  a_ready_irq_raise: assert property (
    s_enable_ready ##1 (ready_now && !MASK_WR_I && !IF_RESET_I
      && !INTR_TAKEN_I) |=> IRQ_O)
    else $error("ready interrupt not raised after enable");

  a_full_mode_ready: assert property (
    FULL_MODE_I && HS_CTL_SET_I |-> !ready_now)
    else $error("full mode ready while control line set");

  a_full_mode_flag: assert property (
    FULL_MODE_I && !HS_CTL_SET_I && !HS_FLAG_READY_I |-> !ready_now)
    else $error("full mode ready without flag ready");

  a_pulse_mode_ready: assert property (
    !FULL_MODE_I |-> ready_now == !HS_CTL_SET_I)
    else $error("pulse mode ready does not follow control line");

  a_ext_irq_level: assert property (
    MASK_O[ppis_pkg::MASK_EXT_BIT] && !EXT_REQ_N_I |=> IRQ_O)
    else $error("external request not reflected on interrupt");

  a_ready_status_read: assert property (
    s_read_ready |=> STATUS_VALID_O && STATUS_DATA_O == {15'h0000, $past(ready_now)})
    else $error("ready status read wrong");

  a_periph_status_read: assert property (
    s_read_periph |=> STATUS_DATA_O == {12'h000, $past(PERIPH_OK_I), !$past(EXT_REQ_N_I),
      ~$past(CAUSE_N_I)})
    else $error("peripheral status read wrong");

  a_irq_follows_level: assert property (
    IRQ_O |-> ($past(mask_r[ppis_pkg::MASK_READY_BIT]) && $past(ready_now))
      || ($past(mask_r[ppis_pkg::MASK_EXT_BIT]) && !$past(EXT_REQ_N_I)))
    else $error("interrupt held without a present source");

  a_data_in_read: assert property (
    STATUS_RD_I && STATUS_ADDR_I == ppis_pkg::REG_DATA_IN |=> STATUS_DATA_O == $past(DATA_IN_I))
    else $error("data in read wrong");

  a_taken_disables: assert property (
    INTR_TAKEN_I && !MASK_WR_I ##1 !MASK_WR_I [*2] |-> MASK_O == 8'h00 ##1 !IRQ_O)
    else $error("interrupt enables survive a taken interrupt");

  a_if_reset_clear: assert property (
    IF_RESET_I |=> MASK_O == 8'h00)
    else $error("interface reset left enables set");

  a_irq_equation: assert property (
    ##1 IRQ_O == (($past(mask_r[ppis_pkg::MASK_READY_BIT]) && $past(ready_now))
      || ($past(mask_r[ppis_pkg::MASK_EXT_BIT]) && !$past(EXT_REQ_N_I))))
    else $error("interrupt request not the gated OR of sources");

  // a mask write that is not overridden by an interface reset
  sequence s_mask_write;
    MASK_WR_I && !IF_RESET_I;
  endsequence

  a_mask_write_lands: assert property (
    s_mask_write |=> MASK_O == $past(MASK_DATA_I))
    else $error("mask write did not land");

  a_valid_read_only: assert property (
    !STATUS_RD_I |=> !STATUS_VALID_O)
    else $error("read valid without a read strobe");

  a_read_data_holds: assert property (
    !STATUS_RD_I |=> $stable(STATUS_DATA_O))
    else $error("read data changed without a read strobe");

  a_masked_no_irq: assert property (
    MASK_O == ppis_pkg::MASK_RESET |=> !IRQ_O)
    else $error("interrupt raised with all enables clear");

  a_ready_only_source: assert property (
    MASK_O[ppis_pkg::MASK_READY_BIT] && !MASK_O[ppis_pkg::MASK_EXT_BIT]
      |=> IRQ_O == $past(ready_now))
    else $error("shared request does not follow the ready source alone");

  a_ext_only_source: assert property (
    MASK_O[ppis_pkg::MASK_EXT_BIT] && !MASK_O[ppis_pkg::MASK_READY_BIT]
      |=> IRQ_O == !$past(EXT_REQ_N_I))
    else $error("shared request does not follow the external source alone");
endmodule : ppis_top
`default_nettype wire

// *** hdl/ppis_pkg.sv ***
// package: register numbers, field positions and reset values of the parallel port status block
package ppis_pkg;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned MASK_W   = 8;
  // status register numbers
  localparam logic [3:0]  REG_DATA_IN      = 4'h3;
  localparam logic [3:0]  REG_READY        = 4'h4;
  localparam logic [3:0]  REG_PERIPH       = 4'h5;
  // interrupt mask field positions
  localparam int unsigned MASK_READY_BIT   = 1;
  localparam int unsigned MASK_EXT_BIT     = 2;
  // peripheral line status field positions
  localparam int unsigned PST_CAUSE0_BIT   = 0;
  localparam int unsigned PST_CAUSE1_BIT   = 1;
  localparam int unsigned PST_EXT_BIT      = 2;
  localparam int unsigned PST_OK_BIT       = 3;
  // values after reset and of unmapped register reads
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [15:0] RDATA_RESET      = 16'h0000;
  localparam logic [15:0] RDATA_UNMAPPED   = 16'h0000;
endpackage : ppis_pkg

// *** hdl/ppis_line_if.sv ***
// interface: present state of the port lines, passed from the top to the status read mux
`timescale 1ns/100ps
`default_nettype none
interface ppis_line_if;
  logic        ready;
  logic        ext_req_low;
  logic        periph_ok;
  logic [1:0]  cause_low;
  logic [15:0] data_in;
  modport src (
    output ready,
    output ext_req_low,
    output periph_ok,
    output cause_low,
    output data_in
  );
  modport mux (
    input  ready,
    input  ext_req_low,
    input  periph_ok,
    input  cause_low,
    input  data_in
  );
endinterface : ppis_line_if
`default_nettype wire

// *** hdl/ppis_status_mux.sv ***
// module: combinational selection of the status register read value
`timescale 1ns/100ps
`default_nettype none
module ppis_status_mux (
  ppis_line_if.mux                     lines,
  input  wire logic [3:0]              addr_i,
  output logic      [15:0]             rdata_o
);
  logic [7:0] periph_byte;

  // peripheral status byte, upper nibble always zero
  always_comb begin
    periph_byte = 8'h00;
    periph_byte[ppis_pkg::PST_OK_BIT]     = lines.periph_ok;
    periph_byte[ppis_pkg::PST_EXT_BIT]    = lines.ext_req_low;
    periph_byte[ppis_pkg::PST_CAUSE1_BIT] = lines.cause_low[1];
    periph_byte[ppis_pkg::PST_CAUSE0_BIT] = lines.cause_low[0];
  end

  // address decode; unmapped numbers read as zero
  always_comb begin
    if (addr_i == ppis_pkg::REG_DATA_IN) begin
      rdata_o = lines.data_in;
    end else if (addr_i == ppis_pkg::REG_READY) begin
      rdata_o = {15'h0000, lines.ready};
    end else if (addr_i == ppis_pkg::REG_PERIPH) begin
      rdata_o = {8'h00, periph_byte};
    end else begin
      rdata_o = ppis_pkg::RDATA_UNMAPPED;
    end
  end
endmodule : ppis_status_mux
`default_nettype wire

// *** testbench/ppis_periph_model.sv ***
// partner model: parallel peripheral driving request, cause and data lines
`timescale 1ns/100ps
`default_nettype none
module ppis_periph_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        raise_i,
  input  wire logic        ack_i,
  input  wire logic [1:0]  cause_i,
  input  wire logic [15:0] code_i,
  output logic             ext_req_n_o,
  output logic      [1:0]  cause_n_o,
  output logic      [15:0] data_o
);
  // request stays low until the host acknowledges, then is withdrawn
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) ext_req_n_o <= 1'b1;
    else if (ack_i) ext_req_n_o <= 1'b1;
    else if (raise_i) ext_req_n_o <= 1'b0;
  end
  // cause shown only with a request; idle data lines carry a changing pattern
  assign cause_n_o = ext_req_n_o ? 2'h3 : ~cause_i;
  assign data_o    = ext_req_n_o ? ~code_i : code_i;
endmodule : ppis_periph_model
`default_nettype wire

// *** testbench/ppis_top_tb.sv ***
// testbench: random line and host traffic compared against a reference model
`timescale 1ns/100ps
`default_nettype none
module ppis_top_tb;
  logic        CLOCK_I, SYS_RST_I, IF_RESET_I, FULL_MODE_I, HS_CTL_SET_I, HS_FLAG_READY_I;
  logic        EXT_REQ_N_I, PERIPH_OK_I, MASK_WR_I, INTR_TAKEN_I, STATUS_RD_I;
  logic        STATUS_VALID_O, IRQ_O, raise, exp_valid, exp_irq, rdy;
  logic [1:0]  CAUSE_N_I, cause;
  logic [3:0]  STATUS_ADDR_I;
  logic [7:0]  MASK_DATA_I, MASK_O, exp_mask;
  logic [15:0] DATA_IN_I, STATUS_DATA_O, code, exp_data, rd_val;
  int          fails, total_checks, seed;

  ppis_top dut (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .IF_RESET_I(IF_RESET_I),
    .FULL_MODE_I(FULL_MODE_I), .HS_CTL_SET_I(HS_CTL_SET_I), .HS_FLAG_READY_I(HS_FLAG_READY_I),
    .EXT_REQ_N_I(EXT_REQ_N_I), .PERIPH_OK_I(PERIPH_OK_I), .CAUSE_N_I(CAUSE_N_I),
    .DATA_IN_I(DATA_IN_I), .MASK_WR_I(MASK_WR_I), .MASK_DATA_I(MASK_DATA_I),
    .INTR_TAKEN_I(INTR_TAKEN_I), .STATUS_ADDR_I(STATUS_ADDR_I), .STATUS_RD_I(STATUS_RD_I),
    .STATUS_DATA_O(STATUS_DATA_O), .STATUS_VALID_O(STATUS_VALID_O), .MASK_O(MASK_O),
    .IRQ_O(IRQ_O));
  ppis_periph_model periph (.clk_i(CLOCK_I), .rst_i(SYS_RST_I), .raise_i(raise),
    .ack_i(INTR_TAKEN_I), .cause_i(cause), .code_i(code), .ext_req_n_o(EXT_REQ_N_I),
    .cause_n_o(CAUSE_N_I), .data_o(DATA_IN_I));

  // clock of 4 ns period
  initial begin
    CLOCK_I = 1'b0;
    forever #2 CLOCK_I = ~CLOCK_I;
  end

  // ready condition and status read value worked out from the line levels
  always_comb begin
    rdy = !HS_CTL_SET_I & (FULL_MODE_I ? HS_FLAG_READY_I : 1'b1);
    case (STATUS_ADDR_I)
      4'h3: rd_val = DATA_IN_I;
      4'h4: rd_val = {15'h0000, rdy};
      4'h5: rd_val = {12'h000, PERIPH_OK_I, ~EXT_REQ_N_I, ~CAUSE_N_I};
      default: rd_val = 16'h0000;
    endcase
  end

  // reference model: mask, request and read path as the host sees them
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      {exp_mask, exp_irq, exp_valid, exp_data} <= '0;
    end else begin
      if (IF_RESET_I) exp_mask <= 8'h00;
      else if (MASK_WR_I) exp_mask <= MASK_DATA_I;
      else if (INTR_TAKEN_I) exp_mask <= 8'h00;
      exp_irq <= (exp_mask[1] & rdy) | (exp_mask[2] & ~EXT_REQ_N_I);
      exp_valid <= STATUS_RD_I;
      if (STATUS_RD_I) exp_data <= rd_val;
    end
  end

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // outputs compared at the falling edge, when registered values have settled
  always @(negedge CLOCK_I) begin
    check("irq", {15'h0000, exp_irq}, {15'h0000, IRQ_O});
    check("mask", {8'h00, exp_mask}, {8'h00, MASK_O});
    check("valid", {15'h0000, exp_valid}, {15'h0000, STATUS_VALID_O});
    if (exp_valid) check("status", exp_data, STATUS_DATA_O);
  end

  // random traffic; writes, acks and interface resets are kept rare
  task automatic drive(input string nm, input int n);
    logic [31:0] r;
    repeat (n) begin
      @(posedge CLOCK_I);
      #1;
      r = $random(seed);
      {FULL_MODE_I, HS_CTL_SET_I, HS_FLAG_READY_I, PERIPH_OK_I, raise, cause, STATUS_RD_I} = r[7:0];
      STATUS_ADDR_I = r[11:8];
      MASK_DATA_I = r[19:12];
      code = r[31:16];
      MASK_WR_I = (r[22:20] == 3'h0);
      INTR_TAKEN_I = (r[25:23] == 3'h0);
      IF_RESET_I = (r[30:26] == 5'h00);
    end
    $display("test %s done", nm);
  endtask : drive

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // watchdog well beyond the planned run
  initial begin
    #40000;
    fails++;
    end_of_test();
  end

  initial begin
    seed = 16;
    {fails, total_checks} = '0;
    {SYS_RST_I, IF_RESET_I, FULL_MODE_I, HS_CTL_SET_I, HS_FLAG_READY_I, PERIPH_OK_I} = 6'h01 << 5;
    {MASK_WR_I, INTR_TAKEN_I, STATUS_RD_I, raise} = '0;
    {cause, STATUS_ADDR_I, MASK_DATA_I, code} = '0;
    repeat (6) @(posedge CLOCK_I);
    #1;
    SYS_RST_I = 1'b0;
    drive("random_traffic", 3000);
    SYS_RST_I = 1'b1;
    drive("reset_mid_run", 3);
    SYS_RST_I = 1'b0;
    drive("after_reset", 2000);
    end_of_test();
  end
endmodule : ppis_top_tb
`default_nettype wire
